// ---- hdl/flash_seq_pkg.sv ----
package flash_seq_pkg;
  localparam int unsigned CTRL_W = 16;
  localparam int unsigned OP_LSB = 0;
  localparam int unsigned OP_W = 4;
  localparam int unsigned ERASE_BIT = 6;
  localparam int unsigned SEQ_ERR_BIT = 13;
  localparam int unsigned FLASH_WRITE_ENABLE_BIT_BIT = 14;
  localparam int unsigned START_BIT = 15;
  localparam logic [3:0] OP_ROW_PROGRAM = 4'h1;
  localparam logic [3:0] OP_PAGE_ERASE = 4'h2;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam int unsigned ROWS_PER_PAGE = 8;
  localparam int unsigned ROW_WORDS = 64;
  localparam int unsigned WORD_W = 24;
  localparam int unsigned ADDR_W = 24;
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_KEY = 2'h1;
  localparam logic [1:0] REG_LATCH_LOW = 2'h2;
  localparam logic [1:0] REG_LATCH_HIGH = 2'h3;
  localparam int unsigned ERASE_TIME_US = 20;
  localparam int unsigned PROG_TIME_US = 2;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
  localparam int unsigned PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam logic [7:0] CSR_CTRL = 8'h00;
  localparam logic [7:0] CSR_KEY = 8'h04;
  localparam logic [7:0] CSR_ADDR = 8'h08;
  localparam logic [7:0] CSR_LOW = 8'h0c;
  localparam logic [7:0] CSR_HIGH = 8'h10;
  localparam logic [7:0] CSR_STATUS = 8'h14;
  localparam logic [7:0] CSR_READ = 8'h18;
  localparam logic [7:0] CSR_RDATA = 8'h1c;
endpackage : flash_seq_pkg

// ---- hdl/flash_seq_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface flash_seq_if;
  import flash_seq_pkg::*;
  logic wr;
  logic [1:0] sel;
  logic [15:0] wdata;
  logic [ADDR_W-1:0] addr;
  logic [CTRL_W-1:0] ctrl;
  logic stall;
  logic rd;
  logic [WORD_W-1:0] rdata;
  modport dev (input wr, sel, wdata, addr, rd, output ctrl, stall, rdata);
  modport cpu (output wr, sel, wdata, addr, rd, input ctrl, stall, rdata);
endinterface : flash_seq_if
`default_nettype wire

// ---- hdl/flash_row_program_page_erase.sv ----
`timescale 1ns/100ps
`default_nettype none
module flash_row_program_page_erase
  import flash_seq_pkg::*;
#(
  parameter int unsigned ERASE_CNT = ERASE_CYCLES,
  parameter int unsigned PROG_CNT = PROG_CYCLES,
  parameter int unsigned ROWS = 64
)(
  input wire logic clk_sys,
  input wire logic rst_n,
  flash_seq_if.dev bus
);
  localparam int unsigned PAGE_WORDS = ROW_WORDS * ROWS_PER_PAGE;
  localparam int unsigned DEPTH = ROW_WORDS * ROWS;
  localparam int unsigned IW = $clog2(DEPTH);
  localparam int unsigned CW = 32;

  // The array holds whole pages only, and a cycle needs at least one count.
  // Other row counts would leave part of a page without cells.
  if (ROWS == 0 || ROWS % ROWS_PER_PAGE != 0 ||
      ERASE_CNT < 1 || PROG_CNT < 1)
  begin : g_bad_params
    $error("flash sequencer parameters out of range");
  end

  // One-hot states; a cycle runs in ST_ERASE or ST_PROG until done.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ERASE = 3'b010,
    ST_PROG = 3'b100
  } state_t;

  // Every device write that is not the next key drops the unlock, so only
  // 55, AA and the start in direct order open a cycle.
  typedef enum logic [1:0] {
    KEY_NONE = 2'h0,
    KEY_HALF = 2'h1,
    KEY_OPEN = 2'h2
  } key_t;

  logic [WORD_W-1:0] flash_mem [DEPTH];
  logic [WORD_W-1:0] latch_mem [ROW_WORDS];
  state_t state_q, state_d;
  key_t key_q, key_d;
  logic [3:0] op_q, op_d;
  logic erase_q, erase_d, flash_write_enable_bit_q, flash_write_enable_bit_d, err_q, err_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [15:0] low_q, low_d;
  logic [IW-1:0] base_q, base_d;
  logic [WORD_W-1:0] rdata_q;
  logic [5:0] lat_idx;
  logic start_req, erase_ok, prog_ok, done;

  // The latch index is the word offset within a row of ROW_WORDS words.
  assign lat_idx = bus.addr[6:1];
  assign start_req = bus.wr && bus.sel == REG_CTRL && bus.wdata[START_BIT];
  // The ending cycle is checked again against the code held in the register.
  assign erase_ok = op_q == OP_PAGE_ERASE && erase_q;
  assign prog_ok = op_q == OP_ROW_PROGRAM && !erase_q;
  assign done = cnt_q == '0;

  always_comb
  begin
    state_d = state_q;
    key_d = key_q;
    op_d = op_q;
    erase_d = erase_q;
    flash_write_enable_bit_d = flash_write_enable_bit_q;
    err_d = err_q;
    cnt_d = cnt_q;
    low_d = low_q;
    base_d = base_q;
    // The counter starts one below the cycle length, so the core stalls for
    // exactly ERASE_CNT or PROG_CNT cycles.
    if (state_q != ST_IDLE)
    begin
      cnt_d = cnt_q - 1'b1;
      if (done)
      begin
        state_d = ST_IDLE;
        cnt_d = '0;
      end
    end
    else if (bus.wr)
    begin
      key_d = KEY_NONE;
      case (bus.sel)
        REG_KEY:
          if (bus.wdata[7:0] == KEY_FIRST)
            key_d = KEY_HALF;
          else if (key_q == KEY_HALF && bus.wdata[7:0] == KEY_SECOND)
            key_d = KEY_OPEN;
        REG_LATCH_LOW:
        begin
          // The erase or program base follows the last low latch write.
          low_d = bus.wdata;
          base_d = IW'(bus.addr[ADDR_W-1:1]);
        end
        REG_CTRL:
        begin
          op_d = bus.wdata[OP_LSB +: OP_W];
          erase_d = bus.wdata[ERASE_BIT];
          flash_write_enable_bit_d = bus.wdata[FLASH_WRITE_ENABLE_BIT_BIT];
          // A failed start sets the flag even if this write clears it.
          err_d = bus.wdata[SEQ_ERR_BIT] & err_q;
          if (start_req)
          begin
            if (key_q != KEY_OPEN || !bus.wdata[FLASH_WRITE_ENABLE_BIT_BIT])
              err_d = 1'b1;
            else if (bus.wdata[OP_LSB +: OP_W] == OP_PAGE_ERASE &&
                     bus.wdata[ERASE_BIT])
            begin
              state_d = ST_ERASE;
              cnt_d = CW'(ERASE_CNT - 1);
            end
            else if (bus.wdata[OP_LSB +: OP_W] == OP_ROW_PROGRAM &&
                     !bus.wdata[ERASE_BIT])
            begin
              state_d = ST_PROG;
              cnt_d = CW'(PROG_CNT - 1);
            end
            // A code that names no operation is refused like a keyless start.
            else
              err_d = 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      key_q <= KEY_NONE;
      op_q <= 4'h0;
      erase_q <= 1'b0;
      flash_write_enable_bit_q <= 1'b0;
      err_q <= 1'b0;
      cnt_q <= '0;
      low_q <= 16'h0000;
      base_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      key_q <= key_d;
      op_q <= op_d;
      erase_q <= erase_d;
      flash_write_enable_bit_q <= flash_write_enable_bit_d;
      err_q <= err_d;
      cnt_q <= cnt_d;
      low_q <= low_d;
      base_q <= base_d;
    end
  end

  // Array contents have no reset, as real flash keeps its cells.
  always_ff @(posedge clk_sys)
  begin
    if (state_q == ST_IDLE && bus.wr && bus.sel == REG_LATCH_HIGH)
      latch_mem[lat_idx] <= {bus.wdata[7:0], low_q};
    // Erase leaves the whole page at all ones, as blank flash reads.
    if (state_q == ST_ERASE && done && erase_ok)
    begin
      for (int i = 0; i < PAGE_WORDS; i++)
        flash_mem[(int'(base_q) / PAGE_WORDS) * PAGE_WORDS + i] <=
          {WORD_W{1'b1}};
    end
    // Latches that were not reloaded still hold their last word.
    if (state_q == ST_PROG && done && prog_ok)
    begin
      for (int i = 0; i < ROW_WORDS; i++)
        flash_mem[(int'(base_q) / ROW_WORDS) * ROW_WORDS + i] <=
          latch_mem[i];
    end
    // The read word moves only on a read strobe, so it stands until taken.
    if (bus.rd)
      rdata_q <= flash_mem[IW'(bus.addr[ADDR_W-1:1])];
  end

  assign bus.stall = state_q != ST_IDLE;
  assign bus.rdata = rdata_q;
  // Bit 15 reads as busy, which is how software sees the start bit clear.
  assign bus.ctrl = {state_q != ST_IDLE, flash_write_enable_bit_q, err_q, 6'h00, erase_q,
                     2'h0, op_q};
endmodule : flash_row_program_page_erase
`default_nettype wire

// ---- hdl/flash_seq_cpu.sv ----
`timescale 1ns/100ps
`default_nettype none
module flash_seq_cpu
  import flash_seq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  flash_seq_if.cpu link,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  typedef enum logic [2:0] {
    C_IDLE = 3'b001,
    C_FETCH = 3'b010,
    C_DONE = 3'b100
  } cst_t;
  cst_t st_q, st_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [WORD_W-1:0] rd_q, rd_d;
  logic [31:0] rdata_q, rdata_d;
  logic go;

  // Writes into the device wait while it stalls the core. Every read takes
  // two wait cycles: the answer then leaves a register, and a flash read
  // sees an address written just before it.
  assign avs_waitrequest = (avs_write && link.stall) ||
    (avs_read && st_q != C_DONE);
  assign go = avs_write && !link.stall;

  always_comb
  begin
    link.wr = 1'b0;
    link.sel = REG_CTRL;
    link.wdata = avs_writedata[15:0];
    link.rd = avs_read && st_q == C_IDLE && avs_address == CSR_READ;
    link.addr = addr_q;
    st_d = st_q;
    addr_d = addr_q;
    rd_d = rd_q;
    rdata_d = rdata_q;
    if (go)
      case (avs_address)
        CSR_CTRL: link.wr = 1'b1;
        CSR_KEY:
        begin
          link.wr = 1'b1;
          link.sel = REG_KEY;
        end
        CSR_ADDR: addr_d = avs_writedata[ADDR_W-1:0];
        CSR_LOW:
        begin
          link.wr = 1'b1;
          link.sel = REG_LATCH_LOW;
        end
        CSR_HIGH:
        begin
          link.wr = 1'b1;
          link.sel = REG_LATCH_HIGH;
          addr_d = addr_q + ADDR_W'(2);
        end
        default: ;
      endcase
    // The last flash word read stays readable at the flash data offset.
    case (st_q)
      C_IDLE:
        if (avs_read)
          st_d = C_FETCH;
      C_FETCH:
      begin
        st_d = C_DONE;
        case (avs_address)
          CSR_CTRL: rdata_d = {16'h0000, link.ctrl};
          CSR_ADDR: rdata_d = {8'h00, addr_q};
          CSR_STATUS: rdata_d = {31'h0, link.stall};
          CSR_READ:
          begin
            rdata_d = {8'h00, link.rdata};
            rd_d = link.rdata;
          end
          CSR_RDATA: rdata_d = {8'h00, rd_q};
          default: rdata_d = 32'h0000_0000;
        endcase
      end
      C_DONE: st_d = C_IDLE;
      default: st_d = C_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= C_IDLE;
      addr_q <= '0;
      rd_q <= '0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      st_q <= st_d;
      addr_q <= addr_d;
      rd_q <= rd_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata = rdata_q;
endmodule : flash_seq_cpu
`default_nettype wire

// ---- sim/flash_seq_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module flash_seq_sva
  import flash_seq_pkg::*;
#(
  parameter int unsigned ERASE_CNT = ERASE_CYCLES,
  parameter int unsigned PROG_CNT = PROG_CYCLES
)(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr,
  input wire logic [1:0] sel,
  input wire logic [15:0] wdata,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [CTRL_W-1:0] ctrl,
  input wire logic stall,
  input wire logic rd,
  input wire logic [WORD_W-1:0] rdata
);
  logic k1_q, k1_d, k2_q, k2_d, start_w, op_ok;
  logic [15:0] cnt_q, cnt_d;
  // Any other device write between the keys spoils the unlock.
  always_comb
  begin
    k1_d = k1_q;
    k2_d = k2_q;
    if (wr)
    begin
      k1_d = sel == REG_KEY && wdata[7:0] == KEY_FIRST;
      k2_d = sel == REG_KEY && wdata[7:0] == KEY_SECOND && k1_q;
    end
    cnt_d = stall ? cnt_q + 16'h1 : 16'h0;
  end
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      k1_q <= 1'b0;
      k2_q <= 1'b0;
      cnt_q <= 16'h0;
    end
    else
    begin
      k1_q <= k1_d;
      k2_q <= k2_d;
      cnt_q <= cnt_d;
    end
  assign start_w = wr && sel == REG_CTRL && wdata[START_BIT];
  assign op_ok = wdata[ERASE_BIT] ? wdata[3:0] == OP_PAGE_ERASE
                                  : wdata[3:0] == OP_ROW_PROGRAM;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence go_ok;
    start_w && k2_q && wdata[FLASH_WRITE_ENABLE_BIT_BIT] && op_ok;
  endsequence
  sequence refused;
    !stall && ctrl[SEQ_ERR_BIT] && !ctrl[START_BIT];
  endsequence
  reset_idle_a: assert property ($rose(rst_n) |-> ctrl == 16'h0 && !stall)
    else $error("not idle after reset");
  stall_busy_a: assert property (stall |-> ctrl[START_BIT])
    else $error("stall without busy");
  unlock_start_a: assert property (go_ok |=> stall && ctrl[START_BIT])
    else $error("unlocked start did not run");
  no_key_a: assert property (start_w && !k2_q |=> refused)
    else $error("start without keys not refused");
  bad_op_a: assert property (
    start_w && k2_q && wdata[FLASH_WRITE_ENABLE_BIT_BIT] && !op_ok |=> refused)
    else $error("bad op not refused");
  no_flash_write_enable_bit_a: assert property (start_w && !wdata[FLASH_WRITE_ENABLE_BIT_BIT] |=> refused)
    else $error("start without enable not refused");
  cycle_len_a: assert property ($fell(stall) |-> !ctrl[START_BIT] &&
    cnt_q == (ctrl[ERASE_BIT] ? ERASE_CNT : PROG_CNT))
    else $error("cycle length wrong");
  err_clear_a: assert property (wr && sel == REG_CTRL &&
    !wdata[START_BIT] && !wdata[SEQ_ERR_BIT] |=> !ctrl[SEQ_ERR_BIT])
    else $error("error flag not cleared");
  rd_wr_excl_a: assert property (rd |-> !wr)
    else $error("read and write strobes together");
  addr_hold_a: assert property (stall |-> $stable(addr))
    else $error("table address moved while stalled");
  rdata_hold_a: assert property ($changed(rdata) |-> $past(rd))
    else $error("read word moved without a read");
endmodule : flash_seq_sva
`default_nettype wire

// ---- sim/test_flash_row_program_page_erase.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_flash_row_program_page_erase;
  import flash_seq_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rv;
  logic avs_waitrequest;
  logic [31:0] bad [5] = '{32'hc000, 32'hc003, 32'hc002, 32'hc041, 32'h8001};
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  flash_seq_if bus_if();
  always #4 clk_sys = ~clk_sys;
  flash_row_program_page_erase #(.ERASE_CNT(8), .PROG_CNT(8))
    u_flash_row_program_page_erase (.clk_sys(clk_sys), .rst_n(rst_n),
    .bus(bus_if));
  flash_seq_cpu u_flash_seq_cpu (.clk_sys(clk_sys), .rst_n(rst_n),
    .link(bus_if), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  flash_seq_sva #(.ERASE_CNT(8), .PROG_CNT(8)) u_flash_seq_sva (
    .clk_sys(clk_sys), .rst_n(rst_n), .wr(bus_if.wr), .sel(bus_if.sel),
    .wdata(bus_if.wdata), .addr(bus_if.addr), .ctrl(bus_if.ctrl),
    .stall(bus_if.stall), .rd(bus_if.rd), .rdata(bus_if.rdata));
  task automatic close_out();
    if (n_fail == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // One idle edge after each transfer keeps the strobe from toggling twice.
  task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk_sys iff avs_waitrequest === 1'b0);
    rv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask : av
  task automatic go(input logic [31:0] c, input logic busy);
    av(1'b1, CSR_KEY, 32'h55);
    av(1'b1, CSR_KEY, 32'haa);
    av(1'b1, CSR_CTRL, c);
    av(1'b0, CSR_STATUS, 32'h0);
    chk(rv, {31'h0, busy});
    do
      av(1'b0, CSR_CTRL, 32'h0);
    while (rv[15] === 1'b1);
  endtask : go
  task automatic peek(input logic [31:0] a, input logic [31:0] e);
    av(1'b1, CSR_ADDR, a);
    av(1'b0, CSR_READ, 32'h0);
    chk(rv, e);
  endtask : peek
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      close_out();
    end
  end
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    av(1'b0, CSR_CTRL, 32'h0);
    chk(rv, 32'h0);
    av(1'b0, CSR_RDATA, 32'h0);
    chk(rv, 32'h0);
    av(1'b1, CSR_CTRL, 32'h4042);
    av(1'b1, CSR_ADDR, 32'h0);
    av(1'b1, CSR_LOW, 32'h0);
    go(32'hc042, 1'b1);
    chk(rv, 32'h4042);
    peek(32'h80, 32'hffffff);
    av(1'b1, CSR_CTRL, 32'h4001);
    av(1'b1, CSR_ADDR, 32'h80);
    for (int i = 0; i < ROW_WORDS; i++)
    begin
      av(1'b1, CSR_LOW, 32'h1000 + i);
      av(1'b1, CSR_HIGH, i);
    end
    av(1'b0, CSR_ADDR, 32'h0);
    chk(rv, 32'h100);
    av(1'b1, CSR_ADDR, 32'h80);
    go(32'hc001, 1'b1);
    chk(rv, 32'h4001);
    peek(32'h80, 32'h1000);
    peek(32'hfe, 32'h3f103f);
    av(1'b0, CSR_RDATA, 32'h0);
    chk(rv, 32'h3f103f);
    peek(32'h100, 32'hffffff);
    foreach (bad[i])
    begin
      av(1'b1, CSR_CTRL, 32'h4001);
      go(bad[i], 1'b0);
      chk(rv & 32'ha000, 32'h2000);
    end
    av(1'b1, CSR_KEY, 32'h55);
    av(1'b1, CSR_LOW, 32'h0);
    av(1'b1, CSR_KEY, 32'haa);
    av(1'b1, CSR_CTRL, 32'hc001);
    av(1'b0, CSR_CTRL, 32'h0);
    chk(rv & 32'ha000, 32'h2000);
    av(1'b1, CSR_CTRL, 32'h4001);
    av(1'b0, CSR_CTRL, 32'h0);
    chk(rv, 32'h4001);
    peek(32'h100, 32'hffffff);
    close_out();
  end
endmodule : test_flash_row_program_page_erase
`default_nettype wire
